/* File: rtl/pcr_core_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module pcr_core_decode
  import pcr_pkg::*;
(
  // strap code
  input  wire logic [2:0] code,
  // ratio in halves
  output logic       [3:0] half,
  output logic             valid
);
  always_comb
  begin
    valid = 1'b1;
    case (code)
      PCR_CORE_3_2: half = 4'h3;
      PCR_CORE_2_1: half = 4'h4;
      PCR_CORE_5_2: half = 4'h5;
      PCR_CORE_3_1: half = 4'h6;
      PCR_CORE_7_2: half = 4'h7;
      default:
      begin
        // low codes are reserved; board must not present them (the board model keeps them off core 0 only; core 1 can still see them)
        half  = 4'h0;
        valid = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: rtl/pcr_pkg.sv */
package pcr_pkg;

  // platform:reference ratio codes
  localparam logic [2:0] PCR_PLAT_4  = 3'h0;
  localparam logic [2:0] PCR_PLAT_5  = 3'h1;
  localparam logic [2:0] PCR_PLAT_6  = 3'h2;
  localparam logic [2:0] PCR_PLAT_8  = 3'h3;
  localparam logic [2:0] PCR_PLAT_10 = 3'h4;
  localparam logic [2:0] PCR_PLAT_12 = 3'h5;

  // core:platform ratio codes, ratio in halves
  localparam logic [2:0] PCR_CORE_3_2 = 3'h3;
  localparam logic [2:0] PCR_CORE_2_1 = 3'h4;
  localparam logic [2:0] PCR_CORE_5_2 = 3'h5;
  localparam logic [2:0] PCR_CORE_3_1 = 3'h6;
  localparam logic [2:0] PCR_CORE_7_2 = 3'h7;

  // reset values of the decoded settings
  localparam logic [3:0] PCR_RST_PLAT_MULT = 4'h0;
  localparam logic [3:0] PCR_RST_CORE_HALF = 4'h0;

  // straps must settle this many ns after power-on reset before they are taken
  localparam int unsigned PCR_POR_SETTLE_NS = 1000;
  localparam int unsigned PCR_CLK_NS        = 100;
  localparam logic [4:0]  PCR_SETTLE_CYC    =
    5'((PCR_POR_SETTLE_NS + PCR_CLK_NS - 1) / PCR_CLK_NS);

  typedef struct packed {
    logic [2:0] bus_address_ratio_strap;
    logic       bus_control_strap;
    logic       address_latch_strap;
    logic       output_enable_strap;
    logic       core1_ratio_strap_hi;
    logic [1:0] core1_ratio_strap_lo;
    logic       mem_async_strap;
    logic       enet2_tx_data_bit5;
  } pcr_straps_t;

  typedef struct packed {
    logic [3:0] plat_mult;
    logic       plat_valid;
    logic [3:0] core0_half;
    logic       core0_valid;
    logic [3:0] core1_half;
    logic       core1_valid;
    logic       mem_async;
    logic       serial_block1_pd;
  } pcr_cfg_t;

endpackage

/* File: rtl/pcr_straps.sv */
`timescale 1ns/1ps
`default_nettype none
module pcr_straps
  import pcr_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // strap pins
  input  wire pcr_straps_t strap_pins,
  // decoded configuration
  output pcr_cfg_t         cfg,
  output logic             cfg_done,
  output logic             mem_clk_sel_pll,
  output logic             platform_bus_clock_sel
);
  typedef enum logic [1:0] {PCR_IDLE, PCR_SETTLE, PCR_HOLD} pcr_state_t;

  pcr_straps_t strap_meta;
  pcr_straps_t strap_sync;
  pcr_state_t  state;
  pcr_state_t  next_state;
  logic [4:0]  cnt;
  logic [4:0]  next_cnt;
  pcr_cfg_t    next_cfg;
  pcr_cfg_t    dec_cfg;
  logic [2:0]  core0_code;
  logic [2:0]  core1_code;
  // per-core decoder results, gathered into dec_cfg by one process
  logic [3:0]  core0_half;
  logic        core0_valid;
  logic [3:0]  core1_half;
  logic        core1_valid;
  logic        latch_now;

  function automatic logic [4:0] plat_mult_of(input logic [2:0] c);
    case (c)
      PCR_PLAT_4:  plat_mult_of = 5'h14;
      PCR_PLAT_5:  plat_mult_of = 5'h15;
      PCR_PLAT_6:  plat_mult_of = 5'h16;
      PCR_PLAT_8:  plat_mult_of = 5'h18;
      PCR_PLAT_10: plat_mult_of = 5'h1a;
      PCR_PLAT_12: plat_mult_of = 5'h1c;
      default:     plat_mult_of = 5'h00;
    endcase
  endfunction

  // pins are asynchronous to core_clk
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      strap_meta <= '0;
      strap_sync <= '0;
    end
    else
    begin
      strap_meta <= strap_pins;
      strap_sync <= strap_meta;
    end
  end

  assign core0_code = {strap_sync.bus_control_strap, strap_sync.address_latch_strap,
                       strap_sync.output_enable_strap};
  assign core1_code = {strap_sync.core1_ratio_strap_hi, strap_sync.core1_ratio_strap_lo};

  pcr_core_decode u_core0 (
    .code  (core0_code),
    .half  (core0_half),
    .valid (core0_valid)
  );

  pcr_core_decode u_core1 (
    .code  (core1_code),
    .half  (core1_half),
    .valid (core1_valid)
  );

  always_comb
  begin
    logic [4:0] pm;
    pm = plat_mult_of(strap_sync.bus_address_ratio_strap);
    dec_cfg.plat_mult        = pm[3:0];
    dec_cfg.plat_valid       = pm[4];
    dec_cfg.mem_async        = strap_sync.mem_async_strap;
    dec_cfg.serial_block1_pd = ~strap_sync.enet2_tx_data_bit5;
    dec_cfg.core0_half       = core0_half;
    dec_cfg.core0_valid      = core0_valid;
    dec_cfg.core1_half       = core1_half;
    dec_cfg.core1_valid      = core1_valid;
  end

  // sample only after the synchroniser has filled with settled levels
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    next_cfg   = cfg;
    case (state)
      PCR_IDLE:
      begin
        next_state = PCR_SETTLE;
        next_cnt   = '0;
      end
      PCR_SETTLE:
      begin
        next_cnt = cnt + 5'h01;
        if (cnt == PCR_SETTLE_CYC - 5'h01)
        begin
          next_cfg   = dec_cfg;
          next_state = PCR_HOLD;
        end
      end
      PCR_HOLD:
      begin
        next_cfg = cfg;
      end
      default:
      begin
        next_state = PCR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state <= PCR_IDLE;
      cnt   <= '0;
      cfg   <= '{plat_mult: PCR_RST_PLAT_MULT, core0_half: PCR_RST_CORE_HALF,
                 core1_half: PCR_RST_CORE_HALF, default: 1'b0};
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
      cfg   <= next_cfg;
    end
  end

  assign cfg_done = (state == PCR_HOLD);
  // one-cycle strobe at the edge where the decoded straps are taken
  assign latch_now = (state == PCR_SETTLE) && (next_state == PCR_HOLD);
  // memory clock mux: pll on memory reference when async
  assign mem_clk_sel_pll = cfg.mem_async;
  // platform clock doubles as core complex bus clock; no separate select exists
  assign platform_bus_clock_sel = 1'b1;

  cfg_frozen_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(cfg_done) |-> $stable(cfg))
    else $error("configuration changed after latch");

  core0_map_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == PCR_SETTLE && next_state == PCR_HOLD && core0_code == 3'h5)
    |=> (cfg.core0_half == 4'h5 && cfg.core0_valid))
    else $error("core0 5:2 decode wrong");

  plat_map_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == PCR_SETTLE && next_state == PCR_HOLD
     && strap_sync.bus_address_ratio_strap == 3'h3)
    |=> (cfg.plat_mult == 4'h8 && cfg.plat_valid))
    else $error("platform 8:1 decode wrong");

  plat_rsvd_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (latch_now && strap_sync.bus_address_ratio_strap >= 3'h6)
    |=> (!cfg.plat_valid && cfg.plat_mult == 4'h0))
    else $error("reserved platform code marked valid");

  serdes_pd_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == PCR_SETTLE && next_state == PCR_HOLD && !strap_sync.enet2_tx_data_bit5)
    |=> cfg.serial_block1_pd)
    else $error("serial block not powered down");

  mem_sel_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    latch_now |=> (mem_clk_sel_pll == $past(strap_sync.mem_async_strap)))
    else $error("memory clock select mismatch");

  done_time_a: assert property (@(posedge core_clk)
    $fell(sys_rst) |-> ##[1:24] cfg_done)
    else $error("straps not latched in time");

  core1_indep_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == PCR_SETTLE && next_state == PCR_HOLD && core1_code == 3'h7)
    |=> cfg.core1_half == 4'h7)
    else $error("core1 decode not independent");

  // reserved codes must come out as invalid and zero
  core1_rsvd_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (latch_now && core1_code < 3'h3) |=> (!cfg.core1_valid && cfg.core1_half == 4'h0))
    else $error("reserved core1 code marked valid");

  core0_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (latch_now && core0_code == 3'h3) |=> (cfg.core0_half == 4'h3 && cfg.core0_valid))
    else $error("core0 3:2 decode wrong");

  plat_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (latch_now && strap_sync.bus_address_ratio_strap == 3'h0)
    |=> (cfg.plat_mult == 4'h4 && cfg.plat_valid))
    else $error("platform 4:1 decode wrong");

  plat_top_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (latch_now && strap_sync.bus_address_ratio_strap == 3'h5)
    |=> (cfg.plat_mult == 4'hc && cfg.plat_valid))
    else $error("platform 12:1 decode wrong");

  serdes_on_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (latch_now && strap_sync.enet2_tx_data_bit5) |=> !cfg.serial_block1_pd)
    else $error("serial block powered down while enabled");

  done_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    cfg_done |=> cfg_done)
    else $error("configuration latch dropped");

  // levels from before the synchroniser filled must never be taken
  done_early_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(sys_rst) |-> (!cfg_done) [*8])
    else $error("straps latched before settling");

endmodule
`default_nettype wire

/* File: verif/pcr_board.sv */
`timescale 1ns/1ps
`default_nettype none
module pcr_board
  import pcr_pkg::*;
(
  // wanted setting
  input  wire pcr_straps_t want,
  // strap network at the pins
  output pcr_straps_t      strap_pins
);
  // resistors only: a reserved core 0 code is never fitted
  always_comb
  begin
    strap_pins = want;
    if ({want.bus_control_strap, want.address_latch_strap, want.output_enable_strap} < 3'h3)
      strap_pins.bus_control_strap = 1'b1;
  end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pcr_pkg::*;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  pcr_straps_t want = '0;
  pcr_straps_t pins;
  pcr_cfg_t    cfg;
  logic        cfg_done;
  logic        mem_sel;
  logic        plat_sel;
  int          mismatches = 0;
  int          num_checks = 0;
  int          seed = 5;
  logic [3:0]  plat_tab [8] = '{4'h4, 4'h5, 4'h6, 4'h8, 4'hA, 4'hC, 4'h0, 4'h0};
  // board reference frequency, value arbitrary; the rate limits hang on it
  localparam int REF_MHZ = 100;

  initial forever #50 core_clk = ~core_clk;

  pcr_board board (.want(want), .strap_pins(pins));
  pcr_straps dut (.core_clk(core_clk), .sys_rst(sys_rst), .strap_pins(pins), .cfg(cfg),
    .cfg_done(cfg_done), .mem_clk_sel_pll(mem_sel), .platform_bus_clock_sel(plat_sel));

  function automatic pcr_cfg_t exp_cfg(pcr_straps_t s);
    pcr_cfg_t   e;
    logic [2:0] c0;
    logic [2:0] c1;
    c0 = {s.bus_control_strap, s.address_latch_strap, s.output_enable_strap};
    c1 = {s.core1_ratio_strap_hi, s.core1_ratio_strap_lo};
    e.plat_mult = plat_tab[s.bus_address_ratio_strap];
    e.plat_valid = s.bus_address_ratio_strap < 3'h6;
    e.core0_half = (c0 >= 3'h3) ? {1'b0, c0} : 4'h0;
    e.core0_valid = c0 >= 3'h3;
    e.core1_half = (c1 >= 3'h3) ? {1'b0, c1} : 4'h0;
    e.core1_valid = c1 >= 3'h3;
    e.mem_async = s.mem_async_strap;
    e.serial_block1_pd = ~s.enet2_tx_data_bit5;
    return e;
  endfunction

  // board keeps core and platform rates in range; memory rate rests on a ratio set elsewhere
  function automatic bit in_limits(pcr_straps_t s);
    int plat;
    int c0;
    int c1;
    plat = REF_MHZ * plat_tab[s.bus_address_ratio_strap];
    c0 = plat * {s.bus_control_strap, s.address_latch_strap, s.output_enable_strap} / 2;
    c1 = plat * {s.core1_ratio_strap_hi, s.core1_ratio_strap_lo} / 2;
    return plat >= 400 && plat <= 600 && c0 >= 800 && c0 <= 1500 && c1 >= 800 && c1 <= 1500;
  endfunction

  task automatic chk(string what, logic [16:0] e, logic [16:0] g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic run_one(pcr_straps_t s);
    int       k;
    pcr_cfg_t e;
    @(posedge core_clk);
    sys_rst <= 1'b1;
    want <= s;
    @(posedge core_clk);
    #1 chk("cfg_in_reset", 17'h0, cfg);
    chk("done_in_reset", 17'h0, {16'h0, cfg_done});
    @(posedge core_clk) sys_rst <= 1'b0;
    k = 0;
    while (cfg_done !== 1'b1 && k < 30)
    begin
      @(posedge core_clk);
      #1 k++;
    end
    e = exp_cfg(pins);
    chk("latency", 17'(1 + PCR_SETTLE_CYC), 17'(k));
    chk("cfg", e, cfg);
    chk("mem_sel", {16'h0, pins.mem_async_strap}, {16'h0, mem_sel});
    chk("plat_sel", 17'h1, {16'h0, plat_sel});
    // straps moving after the latch must not reach the outputs
    @(posedge core_clk) want <= ~s;
    repeat (5) @(posedge core_clk);
    #1 chk("cfg_held", e, cfg);
    chk("done_held", 17'h1, {16'h0, cfg_done});
  endtask

  initial
  begin
    pcr_straps_t s;
    logic [31:0] r;
    for (int n = 0; n < 8; n++)
    begin
      r = $random(seed);
      s = r[10:0];
      s.bus_address_ratio_strap = n[2:0];
      {s.bus_control_strap, s.address_latch_strap, s.output_enable_strap} = n[2:0];
      {s.core1_ratio_strap_hi, s.core1_ratio_strap_lo} = 3'h7 - n[2:0];
      run_one(s);
    end
    for (int n = 0; n < 20; n++)
    begin
      do
      begin
        r = $random(seed);
      end
      while (!in_limits(r[10:0]));
      run_one(r[10:0]);
    end
    test_done;
  end

  initial
  begin
    #500000;
    mismatches++;
    test_done;
  end
endmodule
`default_nettype wire
